// [current_monitor_strobe_sequencer.sv]
// Strobe-driven switch sequencer and pad routing for four current monitors
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module current_monitor_strobe_sequencer (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [3:0] high_pad_level_in,
    input wire logic [3:0] low_pad_level_in,
    output logic [3:0] comp_plus_is_high_pad_out,
    output logic [3:0] comp_minus_is_low_pad_out,
    output logic [3:0] comparator_level_out,
    output logic [3:0] monitor_enable_out,
    output cm_seq_pkg::switches_t [3:0] switches_out,
    output cm_seq_pkg::routing_t [3:0] routing_out,
    output logic [3:0] tracking_out
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0] monitor_strobe_shared_copy;
    logic [cm_seq_pkg::CTRL_W-1:0] ctrl [cm_seq_pkg::NUM_MON];
    logic [7:0] sample_cycles;
    logic [7:0] bbm_cycles;
    cm_seq_pkg::phase_t phase [cm_seq_pkg::NUM_MON];
    logic [3:0] effective_strobe;
    logic [3:0] strobe_prev;

    // Software writes; the shared copy lets one write start several monitors
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            monitor_strobe_shared_copy <= 4'h0;
        end else if (wr_in && addr_in == cm_seq_pkg::REG_SHARED_STROBE) begin
            monitor_strobe_shared_copy <= wdata_in[3:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sample_cycles <= cm_seq_pkg::SAMPLE_CYC_RESET;
            bbm_cycles <= cm_seq_pkg::BBM_CYC_RESET;
        end else if (wr_in && addr_in == cm_seq_pkg::REG_TIMING) begin
            // Zero counts would wrap to a 256-cycle phase, so force at least one cycle
            sample_cycles <= (wdata_in[cm_seq_pkg::SAMPLE_POS +: 8] == 8'h00) ? 8'h01
                : wdata_in[cm_seq_pkg::SAMPLE_POS +: 8];
            bbm_cycles <= (wdata_in[cm_seq_pkg::BBM_POS +: 8] == 8'h00) ? 8'h01
                : wdata_in[cm_seq_pkg::BBM_POS +: 8];
        end
    end

    a_timing_write: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (wr_in && addr_in == cm_seq_pkg::REG_TIMING && wdata_in[cm_seq_pkg::SAMPLE_POS +: 8] != 8'h00)
        |=> sample_cycles == $past(wdata_in[cm_seq_pkg::SAMPLE_POS +: 8]))
        else $error("sample count not written");
    a_timing_floor: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        sample_cycles != 8'h00 && bbm_cycles != 8'h00)
        else $error("zero phase count stored");

    ////////////////////////////////////////////////////////////////////////
    // Per-monitor sequencer and routing

    genvar g;
    generate
        for (g = 0; g < cm_seq_pkg::NUM_MON; g++) begin : gen_mon
            localparam logic [7:0] MY_ADDR = 8'(cm_seq_pkg::REG_MON_BASE + g * cm_seq_pkg::REG_MON_STRIDE);
            logic [7:0] count;
            logic en;
            logic bypass;
            logic tm_bypass;

            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    ctrl[g] <= cm_seq_pkg::CTRL_RESET;
                end else if (wr_in && addr_in == MY_ADDR) begin
                    ctrl[g] <= wdata_in[cm_seq_pkg::CTRL_W-1:0];
                end
            end

            assign en = ctrl[g][cm_seq_pkg::BIT_EN];
            assign bypass = ctrl[g][cm_seq_pkg::BIT_BYPASS];
            assign tm_bypass = ctrl[g][cm_seq_pkg::BIT_TM_BYPASS];
            assign effective_strobe[g] = ctrl[g][cm_seq_pkg::BIT_STB] | monitor_strobe_shared_copy[g];

            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    strobe_prev[g] <= 1'b0;
                end else begin
                    strobe_prev[g] <= effective_strobe[g];
                end
            end

            // Disabled monitor is powered down and parks in idle
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    phase[g] <= cm_seq_pkg::PH_IDLE;
                    count <= 8'h00;
                end else if (!effective_strobe[g] || !en) begin
                    phase[g] <= cm_seq_pkg::PH_IDLE;
                    count <= 8'h00;
                end else begin
                    unique case (phase[g])
                        cm_seq_pkg::PH_IDLE: begin
                            if (!strobe_prev[g]) begin
                                phase[g] <= cm_seq_pkg::PH_SAMPLE;
                                count <= sample_cycles;
                            end
                        end
                        cm_seq_pkg::PH_SAMPLE: begin
                            if (count == 8'h01) begin
                                phase[g] <= cm_seq_pkg::PH_BBM;
                                count <= bbm_cycles;
                            end else begin
                                count <= count - 8'h01;
                            end
                        end
                        cm_seq_pkg::PH_BBM: begin
                            if (count == 8'h01) begin
                                phase[g] <= cm_seq_pkg::PH_TRACK;
                            end else begin
                                count <= count - 8'h01;
                            end
                        end
                        cm_seq_pkg::PH_TRACK: begin
                            phase[g] <= cm_seq_pkg::PH_TRACK;
                        end
                    endcase
                end
            end

            // Switch drive follows phase table
            always_comb begin
                unique case (phase[g])
                    cm_seq_pkg::PH_IDLE: switches_out[g] = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, s4: 1'b0};
                    cm_seq_pkg::PH_SAMPLE: switches_out[g] = '{s1: 1'b0, s2: 1'b0, s3: 1'b1, s4: 1'b0};
                    cm_seq_pkg::PH_BBM: switches_out[g] = '{s1: 1'b0, s2: 1'b0, s3: 1'b0, s4: 1'b0};
                    cm_seq_pkg::PH_TRACK: switches_out[g] = '{s1: 1'b0, s2: 1'b0, s3: 1'b0, s4: 1'b1};
                endcase
            end

            always_comb begin
                routing_out[g].high_pad_to_adc = bypass;
                routing_out[g].amp_to_adc = !bypass;
                // Isolation only closes on an explicit direct-input request, never while monitoring
                routing_out[g].high_iso_closed = ctrl[g][cm_seq_pkg::BIT_ISO] && !en;
                routing_out[g].low_pad_to_adc = tm_bypass;
                routing_out[g].tm_to_adc = !tm_bypass;
                routing_out[g].low_iso_closed = ctrl[g][cm_seq_pkg::BIT_TM_ISO] && tm_bypass && !en;
                routing_out[g].high_channel = (g % 2 == 1) ? cm_seq_pkg::CH_HIGH_ODD : cm_seq_pkg::CH_HIGH_EVEN;
                routing_out[g].low_channel = (g % 2 == 1) ? cm_seq_pkg::CH_LOW_ODD : cm_seq_pkg::CH_LOW_EVEN;
            end

            assign comp_plus_is_high_pad_out[g] = 1'b1;
            assign comp_minus_is_low_pad_out[g] = 1'b1;
            assign comparator_level_out[g] = high_pad_level_in[g] & ~low_pad_level_in[g];
            assign monitor_enable_out[g] = en;
            assign tracking_out[g] = (phase[g] == cm_seq_pkg::PH_TRACK);

            // Sequencer checks
            a_track_exit: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_TRACK && !effective_strobe[g]) |=> phase[g] == cm_seq_pkg::PH_IDLE)
                else $error("track phase did not return to idle");
            a_track_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_TRACK && effective_strobe[g] && en) |=> phase[g] == cm_seq_pkg::PH_TRACK)
                else $error("track phase left while strobe high");
            a_tracking_flag: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                tracking_out[g] == (phase[g] == cm_seq_pkg::PH_TRACK))
                else $error("tracking flag disagrees with phase");
            // Both sources low must bring the monitor home, whichever one raised it
            a_or_strobe: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (!ctrl[g][cm_seq_pkg::BIT_STB] && !monitor_strobe_shared_copy[g])
                |=> phase[g] == cm_seq_pkg::PH_IDLE)
                else $error("monitor not idle after both strobes low");
            a_seq_start: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_IDLE && !strobe_prev[g] && effective_strobe[g] && en)
                |=> phase[g] == cm_seq_pkg::PH_SAMPLE)
                else $error("strobe rise did not start sequence");
            a_no_restart: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_IDLE && strobe_prev[g] && effective_strobe[g])
                |=> phase[g] == cm_seq_pkg::PH_IDLE)
                else $error("held strobe restarted sequence");
            a_sample_exit: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_SAMPLE && effective_strobe[g] && en && count == 8'h01)
                |=> phase[g] == cm_seq_pkg::PH_BBM)
                else $error("sample phase did not end in break-before-make");
            a_bbm_exit: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_BBM && effective_strobe[g] && en && count == 8'h01)
                |=> phase[g] == cm_seq_pkg::PH_TRACK)
                else $error("break-before-make did not end in track");
            a_phase_order: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                phase[g] == cm_seq_pkg::PH_SAMPLE
                |-> $past(phase[g]) == cm_seq_pkg::PH_IDLE || $past(phase[g]) == cm_seq_pkg::PH_SAMPLE)
                else $error("sample phase entered out of order");
            a_bbm_before: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_TRACK && !$past(phase[g] == cm_seq_pkg::PH_TRACK))
                |-> $past(phase[g] == cm_seq_pkg::PH_BBM))
                else $error("track entered without break-before-make");
            a_sample_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_SAMPLE && $past(phase[g]) == cm_seq_pkg::PH_IDLE)
                |-> count == sample_cycles)
                else $error("sample phase length wrong");
            a_bbm_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (phase[g] == cm_seq_pkg::PH_BBM && $past(phase[g]) == cm_seq_pkg::PH_SAMPLE)
                |-> count == bbm_cycles)
                else $error("break-before-make length wrong");
            // S4 closing beside any of S1 to S3 would short the pads together
            a_switch_break: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                !(switches_out[g].s4 && (switches_out[g].s1 || switches_out[g].s2 || switches_out[g].s3)))
                else $error("track switch closed beside input switches");
            a_disable_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                !en |=> phase[g] == cm_seq_pkg::PH_IDLE)
                else $error("disabled monitor left idle");
            a_shared_copy: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (wr_in && addr_in == cm_seq_pkg::REG_SHARED_STROBE)
                |=> monitor_strobe_shared_copy[g] == $past(wdata_in[g]))
                else $error("shared strobe copy not written");

            // Routing checks
            a_mux_excl: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                routing_out[g].high_pad_to_adc != routing_out[g].amp_to_adc)
                else $error("channel fed by both pad and amplifier");
            a_iso_open: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                en |-> !routing_out[g].high_iso_closed && !routing_out[g].low_iso_closed)
                else $error("isolation closed while monitor in use");
            a_high_iso_direct: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (ctrl[g][cm_seq_pkg::BIT_ISO] && !en) |-> routing_out[g].high_iso_closed)
                else $error("high-side isolation not closed for direct input");
            a_tm_replace: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                tm_bypass |-> routing_out[g].low_pad_to_adc && !routing_out[g].tm_to_adc)
                else $error("low pad did not replace temperature output");
            a_low_iso_direct: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                (ctrl[g][cm_seq_pkg::BIT_TM_ISO] && tm_bypass && !en) |-> routing_out[g].low_iso_closed)
                else $error("low-side isolation not closed for direct input");
            a_comp_level: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                comparator_level_out[g] == (high_pad_level_in[g] && !low_pad_level_in[g]))
                else $error("comparator level not high pad over low pad");
            a_channel_map: assert property (@(posedge clock_in) disable iff (!rst_b_in)
                routing_out[g].high_channel == ((g % 2 == 1) ? cm_seq_pkg::CH_HIGH_ODD : cm_seq_pkg::CH_HIGH_EVEN)
                && routing_out[g].low_channel == ((g % 2 == 1) ? cm_seq_pkg::CH_LOW_ODD : cm_seq_pkg::CH_LOW_EVEN))
                else $error("pad channel mapping wrong");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stand the cycle after the read strobe

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_in == cm_seq_pkg::REG_SHARED_STROBE) begin
            next_rdata[3:0] = monitor_strobe_shared_copy;
        end else if (addr_in == cm_seq_pkg::REG_STATUS) begin
            for (int i = 0; i < cm_seq_pkg::NUM_MON; i++) begin
                next_rdata[2*i +: 2] = phase[i];
                next_rdata[8+i] = effective_strobe[i];
            end
        end else if (addr_in == cm_seq_pkg::REG_TIMING) begin
            next_rdata[cm_seq_pkg::SAMPLE_POS +: 8] = sample_cycles;
            next_rdata[cm_seq_pkg::BBM_POS +: 8] = bbm_cycles;
        end else begin
            for (int i = 0; i < cm_seq_pkg::NUM_MON; i++) begin
                if (addr_in == 8'(cm_seq_pkg::REG_MON_BASE + i * cm_seq_pkg::REG_MON_STRIDE)) begin
                    next_rdata[cm_seq_pkg::CTRL_W-1:0] = ctrl[i];
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // Data stand only in cycles that follow a read strobe cycle, so a late sample by the master reads zero
    a_rdata_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data stood without a read");

endmodule : current_monitor_strobe_sequencer

// [cm_seq_pkg.sv]
// Constants and carrier types for the current monitor strobe sequencer
package cm_seq_pkg;
    localparam int NUM_MON = 4;
    localparam int CLK_MHZ = 125;
    // Register offsets (word index times four)
    localparam logic [7:0] REG_SHARED_STROBE = 8'h00;
    localparam logic [7:0] REG_MON_BASE = 8'h04;
    localparam logic [7:0] REG_MON_STRIDE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_TIMING = 8'h18;
    // Per-monitor control field positions
    localparam int BIT_BYPASS = 0;
    localparam int BIT_ISO = 1;
    localparam int BIT_EN = 2;
    localparam int BIT_STB = 3;
    localparam int BIT_TM_BYPASS = 4;
    localparam int BIT_TM_ISO = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    // Timing field layout and reset values (cycles)
    localparam int SAMPLE_POS = 0;
    localparam int BBM_POS = 8;
    localparam logic [7:0] SAMPLE_CYC_RESET = 8'h10;
    localparam logic [7:0] BBM_CYC_RESET = 8'h02;
    // Converter channels used by each block's pads
    localparam logic [3:0] CH_HIGH_EVEN = 4'h3;
    localparam logic [3:0] CH_LOW_EVEN = 4'h4;
    localparam logic [3:0] CH_HIGH_ODD = 4'h7;
    localparam logic [3:0] CH_LOW_ODD = 4'h8;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_BBM = 2'b11,
        PH_TRACK = 2'b10
    } phase_t;

    // Switch drive for one monitor; 1 means closed
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic s4;
    } switches_t;

    // Pad routing for one monitor
    typedef struct packed {
        logic high_pad_to_adc;
        logic amp_to_adc;
        logic low_pad_to_adc;
        logic tm_to_adc;
        logic high_iso_closed;
        logic low_iso_closed;
        logic [3:0] high_channel;
        logic [3:0] low_channel;
    } routing_t;
endpackage : cm_seq_pkg

// [adc_partner.sv]
// Converter model: one start pulse opens a sampling window, then hold
`timescale 1ns/1ps
module adc_partner #(
    parameter int SAMPLE_CYC = 20
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic track_in,
    output logic sampling_out,
    output logic held_ok_out,
    output logic [7:0] level_avg_out
);
    int count;
    // A start that arrives mid-window is ignored, as a busy converter would
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            count <= 0;
            sampling_out <= 1'b0;
            held_ok_out <= 1'b0;
            level_avg_out <= 8'h00;
        end else if (start_in && count == 0) begin
            count <= SAMPLE_CYC;
            sampling_out <= 1'b1;
            held_ok_out <= track_in;
        end else if (count > 0) begin
            count <= count - 1;
            sampling_out <= (count > 1);
            held_ok_out <= held_ok_out & track_in;
            if (count == 1) begin
                // Recursive average: the newest conversion carries the most weight
                level_avg_out <= level_avg_out - (level_avg_out >> 2) + ((held_ok_out & track_in) ? 8'h40 : 8'h00);
            end
        end
    end
endmodule : adc_partner

// [test_current_monitor_strobe_sequencer.sv]
// Self-checking testbench for the current monitor strobe sequencer
`timescale 1ns/1ps
module test_current_monitor_strobe_sequencer;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] high_pad = 4'h0;
    logic [3:0] low_pad = 4'h0;
    logic adc_start = 1'b0;
    logic [31:0] rdata;
    logic [3:0] cmp_p, cmp_m, cmp_lvl, en, trk;
    cm_seq_pkg::switches_t [3:0] sw;
    cm_seq_pkg::routing_t [3:0] rt;
    logic sampling, held_ok;
    logic [7:0] avg;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int hi_run = 0;
    logic long_strobe = 1'b0;
    current_monitor_strobe_sequencer current_monitor_strobe_sequencer_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .high_pad_level_in(high_pad), .low_pad_level_in(low_pad), .comp_plus_is_high_pad_out(cmp_p),
        .comp_minus_is_low_pad_out(cmp_m), .comparator_level_out(cmp_lvl), .monitor_enable_out(en),
        .switches_out(sw), .routing_out(rt), .tracking_out(trk));
    adc_partner adc_partner_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .start_in(adc_start), .track_in(trk[0]),
        .sampling_out(sampling), .held_ok_out(held_ok), .level_avg_out(avg));
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk
    function automatic cm_seq_pkg::routing_t exp_rt(input int n, input logic [5:0] c);
        cm_seq_pkg::routing_t r;
        r.high_pad_to_adc = c[0];
        r.amp_to_adc = !c[0];
        r.low_pad_to_adc = c[4];
        r.tm_to_adc = !c[4];
        r.high_iso_closed = c[1] & !c[2];
        r.low_iso_closed = c[5] & c[4] & !c[2];
        r.high_channel = n[0] ? 4'h7 : 4'h3;
        r.low_channel = n[0] ? 4'h8 : 4'h4;
        return r;
    endfunction : exp_rt
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_and_map();
        rd_chk(8'h18, 32'h0000_0210);
        rd_chk(8'h14, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000);
        chk(32'(sw), 32'h0000_EEEE);
        wr(8'h18, 32'h0000_0000);
        rd_chk(8'h18, 32'h0000_0101);
        wr(8'h18, 32'h0000_0204);
        @(posedge clock_in);
        high_pad <= 4'h5;
        low_pad <= 4'h3;
        tick(1);
        chk({24'h0, cmp_p, cmp_m}, 32'h0000_00FF);
        chk(32'(cmp_lvl), 32'h0000_0004);
    endtask : test_reset_and_map
    task automatic test_routing();
        logic [5:0] cfg [4] = '{6'h33, 6'h37, 6'h03, 6'h00};
        for (int n = 0; n < 4; n++) begin
            foreach (cfg[i]) begin
                wr(8'h04 + 8'(4 * n), 32'(cfg[i]));
                #1;
                chk(32'(rt[n]), 32'(exp_rt(n, cfg[i])));
            end
        end
    endtask : test_routing
    task automatic test_regular_strobe();
        int k;
        wr(8'h04, 32'h0000_000C);
        tick(2);
        chk(32'(sw[0]), 32'h2);
        tick(2);
        chk(32'(sw[0]), 32'h2);
        tick(1);
        chk(32'(sw[0]), 32'h0);
        tick(1);
        chk(32'(sw[0]), 32'h0);
        tick(1);
        chk(32'(sw[0]), 32'h1);
        rd_chk(8'h14, 32'h0000_0102);
        // Converter start after the amplifier has tracked 124 cycles (992 ns) to settle
        tick(120);
        @(posedge clock_in);
        adc_start <= 1'b1;
        @(posedge clock_in);
        adc_start <= 1'b0;
        tick(2);
        k = 0;
        while (sampling !== 1'b0 && k < 100) begin
            tick(1);
            k++;
        end
        chk(32'(k < 100), 32'h1);
        tick(500);
        chk({31'h0, held_ok}, 32'h1);
        chk(32'(avg), 32'h0000_0040);
        wr(8'h04, 32'h0000_0004);
        tick(2);
        chk(32'(sw[0]), 32'hE);
        tick(700);
    endtask : test_regular_strobe
    task automatic test_shared_strobe();
        for (int n = 0; n < 4; n++) begin
            wr(8'h04 + 8'(4 * n), 32'h0000_0004);
        end
        wr(8'h00, 32'h0000_000F);
        tick(10);
        chk(32'(trk), 32'hF);
        rd_chk(8'h14, 32'h0000_0FAA);
        tick(650);
        wr(8'h08, 32'h0000_000C);
        wr(8'h00, 32'h0000_0000);
        tick(2);
        chk(32'(trk), 32'h2);
        wr(8'h08, 32'h0000_0004);
        tick(2);
        chk(32'(trk), 32'h0);
        tick(700);
    endtask : test_shared_strobe
    task automatic test_enable();
        wr(8'h04, 32'h0000_0008);
        tick(10);
        chk({28'h0, trk}, 32'h0);
        chk({28'h0, en}, 32'hE);
        wr(8'h04, 32'h0000_000C);
        tick(10);
        chk({28'h0, trk}, 32'h0);
        tick(620);
        wr(8'h04, 32'h0000_0004);
        tick(700);
        wr(8'h04, 32'h0000_000C);
        tick(10);
        chk({28'h0, trk}, 32'h1);
        wr(8'h04, 32'h0000_0008);
        tick(2);
        chk({28'h0, trk}, 32'h0);
        tick(620);
        wr(8'h04, 32'h0000_0000);
        tick(5);
        chk(32'(long_strobe), 32'h0);
    endtask : test_enable
    ////////////////////////////////////////////////////////////////////////////////
    // Long strobes are flagged: 200 us at 125 MHz is 25000 cycles of tracking
    always @(posedge clock_in) begin
        hi_run <= (trk != 4'h0) ? hi_run + 1 : 0;
        if (hi_run > 25000) begin
            long_strobe <= 1'b1;
        end
    end
    // Ceiling sized well above the roughly 4800 cycles the scenarios need
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        test_reset_and_map();
        test_routing();
        test_regular_strobe();
        test_shared_strobe();
        test_enable();
        stop_test();
    end
endmodule : test_current_monitor_strobe_sequencer
